// [core/pcs_pkg.sv]
/*
  shared constants, code-group values, state types and the 4b/5b tables of the
  100 Mbps coding datapath.
  assumes nothing of its surroundings; imported whole by every design file.
*/
package pcs_pkg;

  // ****************************************
  // widths and counts
  // ****************************************
  localparam int unsigned SYM_W = 5;       // bits in one code-group
  localparam int unsigned NIB_W = 4;       // bits in one mac nibble
  localparam int unsigned SCR_W = 11;      // scrambler register length
  localparam int unsigned SCR_TAP_HI = 10; // feedback taps of the key polynomial
  localparam int unsigned SCR_TAP_LO = 8;
  localparam int unsigned LOCK_BITS = 88;  // idle ones needed for descrambler lock
  localparam int unsigned RUN_W = 7;       // width of the idle run counter
  localparam logic [2:0] BIT_LAST = 3'h4;  // last bit slot of a code-group
  localparam logic [2:0] ZERO_RUN = 3'h0;  // three zeros in a row, compared as a field
  localparam logic [SCR_W-1:0] SCR_SEED = 11'h7ff; // any nonzero start value

  // ****************************************
  // code-groups
  // ****************************************
  localparam logic [4:0] CG_I = 5'h1f; // inter-frame idle
  localparam logic [4:0] CG_J = 5'h18; // first start delimiter half
  localparam logic [4:0] CG_K = 5'h11; // second start delimiter half
  localparam logic [4:0] CG_T = 5'h0d; // first end delimiter half
  localparam logic [4:0] CG_R = 5'h07; // second end delimiter half
  localparam logic [4:0] CG_H = 5'h04; // halt, marks a transmit error
  localparam logic [4:0] CG_P = 5'h00; // low-power idle
  localparam logic [3:0] NIB_LPI = 4'h1;  // nibble that goes with low-power idle
  localparam logic [3:0] NIB_ZERO = 4'h0;

  // mlt-3 phase positions where a line side is driven
  localparam logic [1:0] MLT_POS = 2'h1;
  localparam logic [1:0] MLT_NEG = 2'h3;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND_K = 2'b01,
    TX_DATA = 2'b10,
    TX_SEND_R = 2'b11
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_CHK_K = 2'b01,
    RX_PKT = 2'b10
  } rx_state_t;

  // ****************************************
  // 4b to 5b data table
  // ****************************************
  function automatic logic [4:0] enc_nib(input logic [3:0] nib);
    logic [4:0] cg;
    cg = 5'h1e;
    case (nib)
      4'h0: cg = 5'h1e;
      4'h1: cg = 5'h09;
      4'h2: cg = 5'h14;
      4'h3: cg = 5'h15;
      4'h4: cg = 5'h0a;
      4'h5: cg = 5'h0b;
      4'h6: cg = 5'h0e;
      4'h7: cg = 5'h0f;
      4'h8: cg = 5'h12;
      4'h9: cg = 5'h13;
      4'ha: cg = 5'h16;
      4'hb: cg = 5'h17;
      4'hc: cg = 5'h1a;
      4'hd: cg = 5'h1b;
      4'he: cg = 5'h1c;
      default: cg = 5'h1d;
    endcase
    return cg;
  endfunction

  // reverse table; bit 4 of the result flags a data code-group
  function automatic logic [4:0] dec_cg(input logic [4:0] cg);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (enc_nib(4'(i)) == cg) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

endpackage

// [core/pcs_descram.sv]
/*
  receive descrambler with idle-based lock and forced unlock.
  assumes one received nrz bit per clock and a lock-drop pulse from the
  alignment logic in the coding top.
*/
`timescale 1ns/1ps

module pcs_descram
  import pcs_pkg::*;
(
  input logic clk,
  input logic rst_sync_b,
  input logic bypass,
  input logic sd,
  input logic drop,
  output logic ud,
  output logic locked
);

  // ****************************************
  // key generator and run counter
  // ****************************************
  logic [SCR_W-1:0] lfsr_r; // local copy of the far scrambler
  logic [RUN_W-1:0] run_r;  // consecutive ones seen while hunting
  logic locked_r;
  wire key = lfsr_r[SCR_TAP_HI] ^ lfsr_r[SCR_TAP_LO];
  wire ud_raw = sd ^ key;                  // [R09]
  // while hunting, assume idle: the key bit must be the inverted line bit
  wire fb = locked_r ? key : ~sd;
  wire run_done = (run_r == RUN_W'(LOCK_BITS - 1)) && ud_raw;

  assign ud = bypass ? sd : ud_raw;        // fibre skips the descrambler [R21]
  assign locked = bypass | locked_r;

  // shift every bit; lock after a full run of descrambled ones
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      lfsr_r <= SCR_SEED;
      run_r <= '0;
      locked_r <= 1'b0;
    end else begin
      lfsr_r <= {lfsr_r[SCR_W-2:0], fb};
      if (drop || bypass) begin            // forced unlock restarts the hunt [R11]
        locked_r <= 1'b0;
        run_r <= '0;
      end else if (!locked_r) begin
        run_r <= ud_raw ? run_r + 1'b1 : '0;
        locked_r <= run_done;              // [R10]
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  AST_LOCK_RUN: assert property ($rose(locked_r) |-> $past(run_r) == RUN_W'(LOCK_BITS - 1)) // [R10]
    else $error("lock taken without a full idle run");
  AST_DROP_UNLOCK: assert property (drop && !bypass |=> !locked_r && run_r == '0) // [R11]
    else $error("lock survived a drop request");

endmodule

// [core/pcs_coding.sv]
/*
  100 Mbps coding datapath: 4b/5b with delimiters, scrambler, nrzi and mlt-3
  split on transmit; nrzi decode, descramble, align and 5b/4b on receive.
  assumes clk is the symbol clock (one line bit per cycle) and that the mac
  drives its transmit nibble from logic on clk, sampled on nib_stb.
*/
`timescale 1ns/1ps

// How it works
// R01: each nibble maps to its data code-group
// R02: first two preamble nibbles become J K
// R03: transmit enable low appends T then R
// R04: idle code-groups fill the gap between frames
// R05: low-power idle flagged with error, no enable
// R06: control code-groups inside data raise receive error
// R07: any undefined code-group raises receive error
// R08: 11-bit closed-loop key xored with serial bits
// R09: receiver regenerates the key and xors it
// R10: lock after 88 descrambled ones
// R11: three stray zeros before J drop lock
// R12: symbol after J not K drops lock
// R13: transmit stream always nrzi encoded, no bypass
// R14: nrzi ones split over two alternating streams
// R15: nibbles become a serial bit per clock
// R16: scrambler can be bypassed
// R17: fibre skips scrambler and mlt-3 stage
// R18: copper mode gives mlt-3 output only; tx_ser still carries the nrzi stream in copper mode
// R19: receive decodes, aligns, monitors link, flags bad start
// R20: transmit sequence follows standard transmit machine
// R21: fibre receive skips descrambler
module pcs_coding
  import pcs_pkg::*;
(
  input logic clk,
  input logic rst_b,
  input logic fiber_mode,
  input logic scr_bypass,
  input logic tx_en,
  input logic tx_er,
  input logic [NIB_W-1:0] txd,
  output logic nib_stb,
  output logic tx_ser,
  output logic mlt_p,
  output logic mlt_n,
  input logic rx_line,
  output logic rx_nib_stb,
  output logic rx_dv,
  output logic rx_er,
  output logic [NIB_W-1:0] rxd,
  output logic rx_locked
);

  // ****************************************
  // reset release and pin synchronisers
  // ****************************************
  logic rst_meta_r;     // first stage of the reset release
  logic rst_sync_b;     // released reset used everywhere else
  logic [2:0] pin_meta_r; // first stage, read only by pin_sync_r
  logic [2:0] pin_sync_r; // {rx_line, scr_bypass, fiber_mode} in clk domain

  // reset asserts at once and releases two edges later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_b <= rst_meta_r;
    end
  end

  // straps and the line input come from outside the clock domain
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= {rx_line, scr_bypass, fiber_mode};
      pin_sync_r <= pin_meta_r;
    end
  end

  wire fiber_s = pin_sync_r[0];
  wire bypass_s = pin_sync_r[1];
  wire rx_s = pin_sync_r[2];

  // ****************************************
  // transmit: nibble pacing and code-group machine
  // ****************************************
  logic [2:0] tx_cnt_r;       // bit slot inside the code-group on the wire
  logic [SYM_W-1:0] tx_sh_r;  // code-group being shifted out, msb first
  tx_state_t tx_st_r;
  tx_state_t tx_st_nxt;
  logic [SYM_W-1:0] cg_nxt;   // code-group loaded at the next boundary

  // one nibble per five line bits; the mac presents txd while this is high
  assign nib_stb = (tx_cnt_r == BIT_LAST);

  // next code-group and state, evaluated at each boundary
  always_comb begin
    tx_st_nxt = tx_st_r;
    cg_nxt = CG_I;                          // idle unless told otherwise [R04]
    unique case (tx_st_r)
      TX_IDLE: begin
        if (tx_en) begin
          cg_nxt = CG_J;                    // first preamble nibble [R02]
          tx_st_nxt = TX_SEND_K;
        end else if (tx_er && txd == NIB_LPI) begin
          cg_nxt = CG_P;                    // low-power idle request [R05]
        end
      end
      TX_SEND_K: begin
        cg_nxt = CG_K;                      // second preamble nibble [R02]
        tx_st_nxt = TX_DATA;
      end
      TX_DATA: begin
        if (!tx_en) begin
          cg_nxt = CG_T;                    // end of frame [R03]
          tx_st_nxt = TX_SEND_R;
        end else if (tx_er) begin
          cg_nxt = CG_H;                    // mac flagged an error
        end else begin
          cg_nxt = enc_nib(txd);            // [R01]
        end
      end
      TX_SEND_R: begin
        cg_nxt = CG_R;                      // [R03]
        tx_st_nxt = TX_IDLE;
      end
    endcase
  end

  // load at the boundary, otherwise shift one bit per clock [R15]
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tx_cnt_r <= '0;
      tx_sh_r <= CG_I;
      tx_st_r <= TX_IDLE;
    end else if (nib_stb) begin
      tx_cnt_r <= '0;
      tx_sh_r <= cg_nxt;
      tx_st_r <= tx_st_nxt;                 // [R20]
    end else begin
      tx_cnt_r <= tx_cnt_r + 1'b1;
      tx_sh_r <= {tx_sh_r[SYM_W-2:0], 1'b1};
    end
  end

  // ****************************************
  // transmit: scrambler, nrzi and mlt-3 split
  // ****************************************
  logic [SCR_W-1:0] scr_r;  // free-running key register
  logic nrzi_r;             // line level of the nrzi stream
  logic [1:0] mlt_ph_r;     // position in the 0,+,0,- cycle
  logic mlt_p_r;
  logic mlt_n_r;
  wire scr_key = scr_r[SCR_TAP_HI] ^ scr_r[SCR_TAP_LO];
  // fibre and the bypass both pass code-groups through unscrambled
  wire scr_skip = bypass_s | fiber_s;
  wire scr_bit = tx_sh_r[SYM_W-1] ^ (scr_key & ~scr_skip); // [R08] [R16] [R17]
  wire [1:0] mlt_ph_nxt = mlt_ph_r + {1'b0, scr_bit};

  // the key runs even when bypassed so re-enabling needs no reseed
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      scr_r <= SCR_SEED;
      nrzi_r <= 1'b0;
    end else begin
      scr_r <= {scr_r[SCR_W-2:0], scr_key}; // [R08]
      nrzi_r <= nrzi_r ^ scr_bit;           // every one toggles the line [R13]
    end
  end

  // each nrzi transition steps the mlt-3 phase; the two sides alternate
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mlt_ph_r <= '0;
      mlt_p_r <= 1'b0;
      mlt_n_r <= 1'b0;
    end else begin
      mlt_ph_r <= mlt_ph_nxt;
      mlt_p_r <= !fiber_s && mlt_ph_nxt == MLT_POS; // [R14] [R17]
      mlt_n_r <= !fiber_s && mlt_ph_nxt == MLT_NEG; // [R14] [R18]
    end
  end

  assign tx_ser = nrzi_r;
  assign mlt_p = mlt_p_r;
  assign mlt_n = mlt_n_r;

  // ****************************************
  // receive: nrzi decode and descrambler
  // ****************************************
  logic rx_prev_r;          // previous line level
  logic ud;                 // descrambled bit
  logic lock_drop;          // request to abandon lock
  wire nrz = rx_s ^ rx_prev_r; // a transition is a one [R19]

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rx_prev_r <= 1'b0;
    end else begin
      rx_prev_r <= rx_s;
    end
  end

  pcs_descram u_descram (
    .clk(clk),
    .rst_sync_b(rst_sync_b),
    .bypass(fiber_s),                       // [R21]
    .sd(nrz),
    .drop(lock_drop),
    .ud(ud),
    .locked(rx_locked)
  );

  // ****************************************
  // receive: alignment and start-delimiter check
  // ****************************************
  logic [SYM_W-1:0] hist_r; // last five descrambled bits, newest in bit 0
  logic [2:0] rx_cnt_r;     // bit slot once aligned
  rx_state_t rx_st_r;
  rx_state_t rx_st_nxt;
  logic sym_stb;            // a full aligned code-group sits in hist_r
  wire [4:0] dec_w = dec_cg(hist_r);
  wire is_ctl = hist_r == CG_I || hist_r == CG_J || hist_r == CG_K ||
                hist_r == CG_T || hist_r == CG_R;
  wire slot_end = (rx_cnt_r == BIT_LAST);

  // hunt for J, prove K, then cut code-groups every five bits
  always_comb begin
    rx_st_nxt = rx_st_r;
    lock_drop = 1'b0;
    sym_stb = 1'b0;
    unique case (rx_st_r)
      RX_HUNT: begin
        if (rx_locked && hist_r == CG_J) begin
          rx_st_nxt = RX_CHK_K;
        end else if (rx_locked && hist_r[2:0] == ZERO_RUN) begin
          lock_drop = 1'b1;                 // zeros that are not J [R11]
        end
      end
      RX_CHK_K: begin
        if (slot_end && hist_r == CG_K) begin
          rx_st_nxt = RX_PKT;
        end else if (slot_end) begin
          lock_drop = 1'b1;                 // bad start delimiter [R12] [R19]
          rx_st_nxt = RX_HUNT;
        end
      end
      RX_PKT: begin
        sym_stb = slot_end;
        // end delimiter, idle or low-power idle close the frame
        if (slot_end && (hist_r == CG_T || hist_r == CG_I || hist_r == CG_P)) begin
          rx_st_nxt = RX_HUNT;
        end
      end
      default: rx_st_nxt = RX_HUNT;
    endcase
    if (!rx_locked) begin
      rx_st_nxt = RX_HUNT;                  // link integrity lost [R19]
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hist_r <= CG_I;
      rx_cnt_r <= '0;
      rx_st_r <= RX_HUNT;
    end else begin
      hist_r <= {hist_r[SYM_W-2:0], ud};
      rx_cnt_r <= (rx_st_r == RX_HUNT || slot_end) ? 3'h0 : rx_cnt_r + 1'b1;
      rx_st_r <= rx_st_nxt;
    end
  end

  // ****************************************
  // receive: 5b/4b decode to mac outputs
  // ****************************************
  logic rx_dv_r;
  logic rx_er_r;
  logic [NIB_W-1:0] rxd_r;
  logic rx_stb_r;

  // outputs change at each aligned code-group; valid and error clear once out of frame
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rx_dv_r <= 1'b0;
      rx_er_r <= 1'b0;
      rxd_r <= NIB_ZERO;
      rx_stb_r <= 1'b0;
    end else begin
      rx_stb_r <= sym_stb;
      if (sym_stb && hist_r == CG_T) begin
        rx_dv_r <= 1'b0;
        rx_er_r <= 1'b0;
        rxd_r <= NIB_ZERO;
      end else if (sym_stb && hist_r == CG_P) begin
        rx_dv_r <= 1'b0;                    // [R05]
        rx_er_r <= 1'b1;
        rxd_r <= NIB_LPI;
      end else if (sym_stb) begin
        rx_dv_r <= 1'b1;
        rx_er_r <= !dec_w[NIB_W] || is_ctl; // [R06] [R07]
        rxd_r <= dec_w[NIB_W-1:0];
      end else if (rx_st_r != RX_PKT) begin
        rx_dv_r <= 1'b0;
        rx_er_r <= 1'b0;
      end
    end
  end

  assign rx_dv = rx_dv_r;
  assign rx_er = rx_er_r;
  assign rxd = rxd_r;
  assign rx_nib_stb = rx_stb_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  sequence s_start;
    nib_stb && tx_st_r == TX_IDLE && tx_en;
  endsequence
  sequence s_stop;
    nib_stb && tx_st_r == TX_DATA && !tx_en;
  endsequence

  AST_SSD_PAIR: assert property (s_start |=> tx_sh_r == CG_J ##5 tx_sh_r == CG_K) // [R02]
    else $error("start delimiter pair not sent");
  AST_ESD_PAIR: assert property (s_stop |=> tx_sh_r == CG_T ##5 tx_sh_r == CG_R) // [R03]
    else $error("end delimiter pair not sent");
  AST_IDLE_FILL: assert property (s_stop ##10 !tx_en && !tx_er |=> tx_sh_r == CG_I) // [R04]
    else $error("idle not sent after end delimiter");
  AST_DATA_MAP: assert property (nib_stb && tx_st_r == TX_DATA && tx_en && !tx_er
    |=> tx_sh_r == enc_nib($past(txd))) // [R01]
    else $error("data nibble mapped wrongly");
  AST_NRZI: assert property ($past(rst_sync_b) |-> $changed(tx_ser) == $past(scr_bit)) // [R13]
    else $error("line toggle does not follow the serial bit");
  AST_FIBER_QUIET: assert property (fiber_s |=> !mlt_p && !mlt_n) // [R17]
    else $error("mlt-3 drive active in fibre mode");
  AST_MLT_SPLIT: assert property ($rose(mlt_p) |-> !mlt_n ##1 !mlt_n) // [R14]
    else $error("both mlt-3 sides driven");
  AST_BYPASS: assert property (scr_skip |-> scr_bit == tx_sh_r[SYM_W-1]) // [R16]
    else $error("bypass still scrambles");
  AST_BAD_K: assert property (rx_st_r == RX_CHK_K && slot_end && hist_r != CG_K
    |-> lock_drop ##1 rx_st_r == RX_HUNT) // [R12]
    else $error("bad start delimiter kept lock");
  AST_BAD_CODE: assert property (sym_stb && !dec_w[NIB_W] && hist_r != CG_T && hist_r != CG_P
    |=> rx_er && rx_dv && rx_nib_stb) // [R07]
    else $error("invalid code-group not flagged");

endmodule

// [bench/mac_model.sv]
/*
  mac model on the nibble side: sends frames and low-power idle on the
  transmit strobe, and queues every receive strobe that carries valid or error.
  assumes one shared clock and that the coding block samples on nib_stb.
*/
`timescale 1ns/1ps

module mac_model
  import pcs_pkg::*;
(
  input logic clk,
  input logic nib_stb,
  output logic tx_en,
  output logic tx_er,
  output logic [NIB_W-1:0] txd,
  input logic rx_nib_stb,
  input logic rx_dv,
  input logic rx_er,
  input logic [NIB_W-1:0] rxd
);
  // ****************************************
  // transmit side
  // ****************************************
  logic [5:0] rxq[$]; // {valid, error, nibble} per flagged strobe

  initial begin
    tx_en = 1'b0;
    tx_er = 1'b0;
    txd = NIB_ZERO;
  end

  // waits for the sampling edge, then steps just past it so changes never race it
  task automatic stb_edge();
    wait (nib_stb === 1'b1);
    @(posedge clk);
    #1;
  endtask

  // preamble pair, data, then enable low over the two closing slots
  task automatic send(input logic [3:0] d[$], input int er_at);
    tx_en = 1'b1;
    txd = 4'h5;
    stb_edge();
    stb_edge();
    foreach (d[i]) begin
      txd = d[i];
      tx_er = (i == er_at);
      stb_edge();
    end
    tx_en = 1'b0;
    tx_er = 1'b0;
    stb_edge();
    stb_edge(); // next frame may start at the following strobe
  endtask

  // low-power idle: error high with enable low and the lpi nibble
  task automatic lpi(input int n);
    tx_er = 1'b1; // lpi flag
    txd = NIB_LPI;
    repeat (n) stb_edge();
    tx_er = 1'b0;
    txd = NIB_ZERO;
  endtask

  // ****************************************
  // receive side
  // ****************************************
  // idle strobes are not kept, so a check sees only frame and error nibbles
  always @(posedge clk) begin
    if (rx_nib_stb === 1'b1 && (rx_dv === 1'b1 || rx_er === 1'b1)) begin
      rxq.push_back({rx_dv, rx_er, rxd});
    end
  end
endmodule

// [bench/pcs_coding_tb.sv]
/*
  self-checking bench of the coding datapath: frames from the mac model, line
  decoded back to groups, loopback, and hand-made receive streams.
  assumes the design package and the mac model are compiled first.
*/
`timescale 1ns/1ps

module pcs_coding_tb;
  import pcs_pkg::*;
  // ****************************************
  // signals and instances
  // ****************************************
  logic clk = 1'b0;
  logic rst_b, fiber_mode, scr_bypass, tx_en, tx_er, nib_stb, tx_ser, mlt_p, mlt_n;
  logic rx_line, rx_nib_stb, rx_dv, rx_er, rx_locked;
  logic [NIB_W-1:0] txd, rxd;
  logic loop, line_lvl, prev_lvl, last_side, p_d, n_d;
  logic [4:0] win; // last five decoded transmit bits
  logic [10:0] scr = 11'h2a5; // bench scrambler, any nonzero start
  int error_cnt = 0;
  int tests_run = 0;
  int mlt_ups, mlt_bad;
  localparam logic [4:0] CG_TAB[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
    5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

  always #10 clk = ~clk;
  assign rx_line = loop ? tx_ser : line_lvl; // loopback or bench-made line

  pcs_coding DUT (.clk(clk), .rst_b(rst_b), .fiber_mode(fiber_mode),
    .scr_bypass(scr_bypass), .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .nib_stb(nib_stb),
    .tx_ser(tx_ser), .mlt_p(mlt_p), .mlt_n(mlt_n), .rx_line(rx_line),
    .rx_nib_stb(rx_nib_stb), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd), .rx_locked(rx_locked));

  mac_model mac (.clk(clk), .nib_stb(nib_stb), .tx_en(tx_en), .tx_er(tx_er), .txd(txd),
    .rx_nib_stb(rx_nib_stb), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd));

  // mlt-3 watch: never both sides high, and side rises alternate
  always @(posedge clk) begin
    if (mlt_p === 1'b1 && mlt_n === 1'b1) mlt_bad++;
    if (mlt_p === 1'b1 && p_d === 1'b0) begin
      mlt_bad += int'(last_side === 1'b0);
      last_side = 1'b0;
      mlt_ups++;
    end
    if (mlt_n === 1'b1 && n_d === 1'b0) begin
      mlt_bad += int'(last_side === 1'b1);
      last_side = 1'b1;
    end
    p_d = mlt_p;
    n_d = mlt_n;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (exp !== got) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset(input logic fib, input logic byp, input logic lp);
    rst_b = 1'b0;
    fiber_mode = fib;
    scr_bypass = byp;
    loop = lp;
    line_lvl = 1'b0;
    prev_lvl = 1'b0;
    last_side = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    // straps settle a few clocks after release, so mlt-3 may pulse once before
    mlt_ups = 0;
    mlt_bad = 0;
    mac.rxq.delete();
  endtask

  // one nrzi-decoded transmit bit per clock
  task automatic get_bit();
    @(posedge clk);
    #1;
    win = {win[3:0], tx_ser ^ prev_lvl};
    prev_lvl = tx_ser;
  endtask

  // hunts for a start group, then checks each following group
  task automatic tx_expect(input logic [4:0] first, input logic [4:0] exp[$], input string what);
    int n;
    n = 0;
    win = ~first;
    while (win !== first && n < 600) begin
      get_bit();
      n++;
    end
    chk({what, " start"}, 8'(first), 8'(win));
    foreach (exp[i]) begin
      repeat (5) get_bit();
      chk(what, 8'(exp[i]), 8'(win));
    end
  endtask

  // groups after the start group: K, data or halt, T, R, idle
  function automatic void frame_cgs(input logic [3:0] d[$], input int er_at,
                                    output logic [4:0] q[$]);
    q = {CG_K};
    foreach (d[i]) q.push_back((i == er_at) ? CG_H : CG_TAB[d[i]]);
    q = {q, CG_T, CG_R, CG_I, CG_I};
  endfunction

  // an error slot checks only valid and error, its nibble is undefined
  task automatic rx_expect(input logic [3:0] d[$], input int er_at, input string what);
    logic [5:0] got;
    chk({what, " count"}, 8'(d.size()), 8'(mac.rxq.size()));
    foreach (d[i]) begin
      got = (i < mac.rxq.size()) ? mac.rxq[i] : 6'h00;
      if (i == er_at) chk(what, 8'h03, 8'(got[5:4]));
      else chk(what, 8'({2'b10, d[i]}), 8'(got));
    end
  endtask

  // bench line bit: scrambled unless fibre, then nrzi
  task automatic send_bit(input logic b);
    logic k;
    k = scr[10] ^ scr[8];
    scr = {scr[9:0], k};
    line_lvl = line_lvl ^ b ^ (k & ~fiber_mode);
    @(posedge clk);
    #1;
  endtask

  task automatic send_cg(input logic [4:0] cg);
    for (int i = 4; i >= 0; i--) send_bit(cg[i]);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_fiber();
    logic [3:0] d[$];
    logic [4:0] q[$];
    do_reset(1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 16; i++) d.push_back(4'(i));
    frame_cgs(d, -1, q);
    fork
      mac.send(d, -1);
      tx_expect(CG_J, q, "fibre groups"); // all codes
    join
    repeat (20) @(posedge clk);
    #1;
    rx_expect(d, -1, "fibre rx"); // loopback
    chk("fibre mlt", 8'h00, 8'(mlt_ups)); // no mlt
  endtask

  task automatic t_tx_err();
    logic [3:0] d[$];
    logic [4:0] q[$];
    do_reset(1'b1, 1'b0, 1'b1);
    d = {4'h3, 4'hc, 4'h7};
    frame_cgs(d, 1, q);
    fork
      mac.send(d, 1);
      tx_expect(CG_J, q, "halt groups"); // halt
    join
    repeat (20) @(posedge clk);
    #1;
    rx_expect(d, 1, "halt rx"); // error nibble
    fork
      mac.lpi(3);
      tx_expect(CG_P, {CG_P}, "lpi groups"); // lpi
    join
  endtask

  task automatic t_bypass();
    logic [3:0] d[$];
    logic [4:0] q[$];
    do_reset(1'b0, 1'b1, 1'b0);
    d = {4'h0, 4'hf, 4'h9};
    frame_cgs(d, -1, q);
    fork
      mac.send(d, -1);
      tx_expect(CG_J, q, "bypass groups"); // unscrambled
    join
    chk("mlt active", 8'h01, 8'(mlt_ups > 0)); // copper mlt
    chk("mlt order", 8'h00, 8'(mlt_bad)); // alternating sides
  endtask

  task automatic t_copper();
    logic [3:0] d[$];
    int n, ones;
    do_reset(1'b0, 1'b0, 1'b1);
    n = 0;
    while (rx_locked !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("loop lock", 8'h01, 8'(rx_locked)); // idle lock
    ones = 0;
    repeat (40) begin
      get_bit();
      ones += int'(win[0]);
    end
    chk("idle scrambled", 8'h01, 8'(ones < 40)); // key on idle
    d = {4'ha, 4'h1, 4'he, 4'h4, 4'h8};
    mac.send(d[0:1], -1);
    mac.send(d[2:4], -1); // back to back
    repeat (30) @(posedge clk);
    #1;
    rx_expect(d, -1, "copper rx"); // descrambled
    chk("loop mlt order", 8'h00, 8'(mlt_bad)); // alternating sides
  endtask

  task automatic t_lock();
    do_reset(1'b0, 1'b0, 1'b0);
    repeat (85) send_bit(1'b1);
    chk("early lock", 8'h00, 8'(rx_locked)); // needs 88 ones
    repeat (30) send_bit(1'b1);
    chk("lock", 8'h01, 8'(rx_locked)); // locked
    send_cg(5'h08);
    repeat (12) send_bit(1'b1);
    chk("stray zeros", 8'h00, 8'(rx_locked)); // three zeros not J
    repeat (115) send_bit(1'b1);
    chk("relock", 8'h01, 8'(rx_locked)); // locked again
    send_cg(CG_J);
    send_cg(CG_I);
    repeat (6) send_bit(1'b1);
    chk("bad second start", 8'h00, 8'(rx_locked)); // J without K
  endtask

  task automatic t_rx_bad();
    logic [4:0] bad[$];
    logic [3:0] d[$];
    bad = {CG_J, CG_K, CG_R, CG_H, CG_I, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08,
      5'h0c, 5'h10, 5'h19};
    d = {4'h6, 4'hb, 4'h0};
    do_reset(1'b1, 1'b0, 1'b0);
    foreach (bad[i]) begin
      mac.rxq.delete();
      repeat (4) send_cg(CG_I);
      send_cg(CG_J);
      send_cg(CG_K);
      send_cg(CG_TAB[d[0]]);
      send_cg(CG_TAB[d[1]]);
      send_cg(bad[i]);
      send_cg(CG_T);
      send_cg(CG_R);
      repeat (2) send_cg(CG_I);
      rx_expect(d, 2, "rx code"); // control and invalid codes
    end
    // low-power idle after the start pair: one error nibble with valid low
    mac.rxq.delete();
    repeat (4) send_cg(CG_I);
    send_cg(CG_J);
    send_cg(CG_K);
    send_cg(CG_P);
    repeat (3) send_cg(CG_I);
    chk("rx lpi", 8'h11, 8'((mac.rxq.size() == 1) ? mac.rxq[0] : 6'h3f));
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic end_sim();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    do_reset(1'b1, 1'b0, 1'b0);
    t_fiber();
    t_tx_err();
    t_bypass();
    t_copper();
    t_lock();
    t_rx_bad();
    end_sim();
  end

  // watchdog: the run needs some 2000 clocks, this allows ten times that
  initial begin
    #400000;
    error_cnt++;
    end_sim();
  end
endmodule
